// ---- hdl/gateway_supervisor.sv ----
/*
  Gateway supervision: slave response timeout, lockable parameters,
  status reporting, save/recall of configuration, soft-error log.
  Assumes Modbus events, nonvolatile image and hard-error level come
  from logic on the same clock; the register master never waits.
*/
`timescale 1ns/100ps
// How it works
// - Time out a forwarded query when no reply arrives in the window.
// - Window resets to 300 ms, rewritten in milliseconds by software.
// - A timeout posts error code 101 into the Modbus error register.
// - While locked, lockable parameters can be neither read nor written.
// - Locked access is dropped, sets command error and lights the LED.
// - Lock on/off commands control the flag; save stores it.
// - Non-lockable parameters stay writable and savable while locked.
// - Each posted Modbus code sets ESR bit 6, summarised to STB bit 5.
// - Timeout and CRC errors set questionable bits 12/13, summary bit 3.
// - Reading the Modbus error register clears the posted cause.
// - Reading the questionable event register clears its bits.
// - Identity text of 72 characters, writable only while unlocked.
// - Save with parameter 0 copies configuration and I/O to NV memory.
// - Configuration and I/O reload at power-on and on recall 0.
// - Device clear flushes serial buffers; device trigger does nothing.
// - Soft errors pulse the red LED about 100 ms, retriggered.
// - Each cycle with a soft error appends one code, the highest-priority one, to a readable error log.
// - Opening a log session clears all existing log entries.
// - A hard error halts operation and blinks the indicator.
// - Reading the event status register returns it and clears the LED.
module gateway_supervisor #(
  parameter int MS_CYCLES_P = gateway_pkg::MS_CYCLES
) (
  input wire logic i_ref_clk, // System clock
  input wire logic i_reset, // Async reset, active high
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire gateway_pkg::mb_evt_s i_mb, // Modbus engine events
  input wire gateway_pkg::nv_cfg_s i_nv, // Stored configuration image
  input wire logic i_hard_err, // Fatal fault level
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  output gateway_pkg::nv_cfg_s o_nv, // Image to store
  output logic o_nv_save, // Store pulse
  output logic o_ser_flush, // Flush serial buffers pulse
  output logic o_err_led, // Red indicator
  output logic o_srq, // Service request
  output logic o_timeout, // Timeout event pulse
  output logic o_halted, // Hard error halt
  output logic o_lock, // Lock flag
  output logic [7:0] o_slave_addr, // Modbus slave address
  output logic [15:0] o_io // I/O settings
);
  typedef enum logic [0:0] {TO_IDLE = 1'b0, TO_WAIT = 1'b1} to_state_e;
  // Lockable registers: slave address and identity text
  function automatic logic lockable(input logic [7:0] a);
    lockable = (a == gateway_pkg::SLAVE_ADDR_OFS) || (a == gateway_pkg::IDN_PTR_OFS) ||
               (a == gateway_pkg::IDN_DATA_OFS);
  endfunction
  logic [16:0] tick_cnt;
  to_state_e to_state;
  logic [15:0] to_cnt, timeout_ms, mb_err, ques_ev, ques_en, ques_ptr, soft_code;
  logic [7:0] idn [gateway_pkg::IDN_LEN];
  logic [6:0] idn_ptr;
  logic [7:0] esr, ese, sre, led_ms, blink_ms, cmd_op, cmd_param, stb;
  logic [15:0] log_mem [gateway_pkg::LOG_DEPTH];
  logic [3:0] log_wp, log_rp;
  logic [4:0] log_cnt;
  logic ms_tick, mb_posted, boot, locked_hit, wr_ok, rd_ok, timeout_evt, cmd_strobe;
  logic soft_err, log_push, log_pop, log_clear;

  // Access decode; a hard error blocks every register read and write
  assign locked_hit = o_lock && lockable(i_addr) && (i_wr || i_rd);
  assign wr_ok = i_wr && !locked_hit && !o_halted;
  assign rd_ok = i_rd && !locked_hit && !o_halted;
  assign cmd_strobe = wr_ok && (i_addr == gateway_pkg::CMD_OFS);
  assign cmd_op = i_wdata[gateway_pkg::CMD_OP_LSB +: 8];
  assign cmd_param = i_wdata[gateway_pkg::CMD_PARAM_LSB +: 8];

  // Millisecond tick enable, shared by timeout and LED timers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_cnt <= 17'h00000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (tick_cnt == 17'(MS_CYCLES_P - 1));
      tick_cnt <= (tick_cnt == 17'(MS_CYCLES_P - 1)) ? 17'h00000 : tick_cnt + 17'h00001;
    end
  end

  // Response window: armed by the last request byte, stopped by a reply
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      to_state <= TO_IDLE;
      to_cnt <= 16'h0000;
    end else if (o_halted) begin
      to_state <= TO_IDLE;
    end else begin
      case (to_state)
        TO_IDLE: begin
          to_cnt <= 16'h0000;
          if (i_mb.req_sent) begin
            to_state <= TO_WAIT;
          end
        end
        TO_WAIT: begin
          if (i_mb.reply_seen) begin
            to_state <= TO_IDLE;
          end else if (to_cnt >= timeout_ms) begin
            to_state <= TO_IDLE;
          end else if (ms_tick) begin
            to_cnt <= to_cnt + 16'h0001;
          end
        end
        default: to_state <= TO_IDLE;
      endcase
    end
  end
  assign timeout_evt = (to_state == TO_WAIT) && !i_mb.reply_seen && (to_cnt >= timeout_ms);
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_timeout <= 1'b0;
    end else begin
      o_timeout <= timeout_evt && !o_halted;
    end
  end
  // Configuration held in NV image: lock, window, slave address, I/O
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      boot <= 1'b1;
      o_lock <= 1'b0;
      timeout_ms <= gateway_pkg::TIMEOUT_RESET_MS;
      o_slave_addr <= gateway_pkg::SLAVE_ADDR_RESET;
      o_io <= 16'h0000;
    end else begin
      boot <= 1'b0;
      if (boot || (cmd_strobe && cmd_op == gateway_pkg::OP_RECALL && cmd_param == 8'h00)) begin
        o_lock <= i_nv.lock;
        timeout_ms <= i_nv.timeout_ms;
        o_slave_addr <= i_nv.slave_addr;
        o_io <= i_nv.io;
      end else if (wr_ok) begin
        case (i_addr)
          gateway_pkg::CMD_OFS: begin
            if (cmd_op == gateway_pkg::OP_LOCK_ON) begin
              o_lock <= 1'b1;
            end else if (cmd_op == gateway_pkg::OP_LOCK_OFF) begin
              o_lock <= 1'b0;
            end
          end
          gateway_pkg::TIMEOUT_OFS: timeout_ms <= i_wdata[15:0];
          gateway_pkg::SLAVE_ADDR_OFS: o_slave_addr <= i_wdata[7:0];
          gateway_pkg::IO_OFS: o_io <= i_wdata[15:0];
          default: o_io <= o_io;
        endcase
      end
    end
  end
  // Save: a non-zero parameter is refused as a command error
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_nv_save <= 1'b0;
      o_nv <= '0;
    end else begin
      o_nv_save <= cmd_strobe && cmd_op == gateway_pkg::OP_SAVE && cmd_param == 8'h00;
      if (cmd_strobe && cmd_op == gateway_pkg::OP_SAVE && cmd_param == 8'h00) begin
        o_nv <= '{lock: o_lock, timeout_ms: timeout_ms, slave_addr: o_slave_addr,
                  io: o_io};
      end
    end
  end
  // Device clear flushes buffers; device trigger is accepted and ignored
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ser_flush <= 1'b0;
    end else begin
      o_ser_flush <= cmd_strobe && cmd_op == gateway_pkg::OP_DEV_CLEAR;
    end
  end
  // Identity text; pointer auto-advances so the host streams characters
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      idn_ptr <= 7'h00;
    end else if (wr_ok && i_addr == gateway_pkg::IDN_PTR_OFS) begin
      idn_ptr <= i_wdata[6:0];
    end else if ((wr_ok || rd_ok) && i_addr == gateway_pkg::IDN_DATA_OFS &&
                 idn_ptr < 7'(gateway_pkg::IDN_LEN - 1)) begin
      idn_ptr <= idn_ptr + 7'h01;
    end
  end
  // Text storage has no reset: it is content, not control
  always_ff @(posedge i_ref_clk) begin
    if (wr_ok && i_addr == gateway_pkg::IDN_DATA_OFS && idn_ptr < 7'(gateway_pkg::IDN_LEN)) begin
      idn[idn_ptr] <= i_wdata[7:0];
    end
  end
  // Modbus error register; a new code beats a simultaneous read-clear
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      mb_err <= 16'h0000;
      mb_posted <= 1'b0;
    end else if (timeout_evt && !o_halted) begin
      mb_err <= gateway_pkg::ERR_MB_TIMEOUT;
      mb_posted <= 1'b1;
    end else if (i_mb.crc_err && !o_halted) begin
      mb_err <= gateway_pkg::ERR_MB_CRC;
      mb_posted <= 1'b1;
    end else if (i_mb.err_valid && !o_halted) begin
      mb_err <= i_mb.err_code;
      mb_posted <= 1'b1;
    end else if (rd_ok && i_addr == gateway_pkg::MB_ERR_OFS) begin
      mb_posted <= 1'b0;
    end
  end

  // Soft-error source: locked access or any Modbus fault
  always_comb begin
    soft_code = i_mb.err_code;
    if (locked_hit) begin
      soft_code = gateway_pkg::ERR_LOCKED_ACCESS;
    end else if (timeout_evt) begin
      soft_code = gateway_pkg::ERR_MB_TIMEOUT;
    end else if (i_mb.crc_err) begin
      soft_code = gateway_pkg::ERR_MB_CRC;
    end
    soft_err = !o_halted && (locked_hit || timeout_evt || i_mb.crc_err || i_mb.err_valid);
  end

  // Event status: command error on refused access; bit 6 follows posting
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      esr <= 8'h00;
    end else begin
      if (rd_ok && i_addr == gateway_pkg::ESR_OFS) begin
        esr <= 8'h00;
      end
      if (locked_hit || (cmd_strobe && (cmd_op == gateway_pkg::OP_SAVE ||
          cmd_op == gateway_pkg::OP_RECALL) && cmd_param != 8'h00)) begin
        esr[gateway_pkg::ESR_CMD_ERR_BIT] <= 1'b1;
      end
      if (rd_ok && i_addr == gateway_pkg::LOG_DATA_OFS && log_cnt == 5'h00) begin
        esr[gateway_pkg::ESR_QUERY_ERR_BIT] <= 1'b1;
      end
    end
  end

  // Enable masks and transition filter
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ese <= 8'h00;
      sre <= 8'h00;
      ques_en <= 16'h0000;
      ques_ptr <= gateway_pkg::QUES_PTR_RESET;
    end else if (wr_ok) begin
      case (i_addr)
        gateway_pkg::ESE_OFS: ese <= i_wdata[7:0];
        gateway_pkg::SRE_OFS: sre <= i_wdata[7:0];
        gateway_pkg::QUES_ENABLE_OFS: ques_en <= i_wdata[15:0];
        gateway_pkg::QUES_PTR_OFS: ques_ptr <= i_wdata[15:0];
        default: sre <= sre;
      endcase
    end
  end

  // Questionable events: rising error pulses pass the filter, set beats clear
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ques_ev <= 16'h0000;
    end else begin
      if (rd_ok && i_addr == gateway_pkg::QUES_EVENT_OFS) begin
        ques_ev <= 16'h0000;
      end
      if (timeout_evt && !o_halted && ques_ptr[gateway_pkg::QUES_TIMEOUT_BIT]) begin
        ques_ev[gateway_pkg::QUES_TIMEOUT_BIT] <= 1'b1;
      end
      if (i_mb.crc_err && !o_halted && ques_ptr[gateway_pkg::QUES_CRC_BIT]) begin
        ques_ev[gateway_pkg::QUES_CRC_BIT] <= 1'b1;
      end
    end
  end

  // Status byte summaries, recomputed live so SRQ drops with its cause
  always_comb begin
    stb = 8'h00;
    stb[gateway_pkg::STB_QUES_BIT] = |(ques_ev & ques_en);
    stb[gateway_pkg::STB_ESR_BIT] = |({esr[7], mb_posted, esr[5:0]} & ese);
    stb[gateway_pkg::STB_MSS_BIT] = |(stb & sre);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_srq <= 1'b0;
    end else begin
      o_srq <= stb[gateway_pkg::STB_MSS_BIT];
    end
  end

  // Error log ring: oldest entry is overwritten when full
  assign log_clear = cmd_strobe && cmd_op == gateway_pkg::OP_LOG_OPEN;
  assign log_push = soft_err;
  assign log_pop = rd_ok && i_addr == gateway_pkg::LOG_DATA_OFS && log_cnt != 5'h00;

  always_ff @(posedge i_ref_clk) begin
    if (log_push) begin
      log_mem[log_wp] <= soft_code;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      log_wp <= 4'h0;
      log_rp <= 4'h0;
      log_cnt <= 5'h00;
    end else if (log_clear) begin
      log_wp <= 4'h0;
      log_rp <= 4'h0;
      log_cnt <= 5'h00;
    end else begin
      if (log_push) begin
        log_wp <= log_wp + 4'h1;
      end
      if (log_pop || (log_push && log_cnt == 5'(gateway_pkg::LOG_DEPTH))) begin
        log_rp <= log_rp + 4'h1;
      end
      if (log_push && !log_pop && log_cnt != 5'(gateway_pkg::LOG_DEPTH)) begin
        log_cnt <= log_cnt + 5'h01;
      end else if (log_pop && !log_push) begin
        log_cnt <= log_cnt - 5'h01;
      end
    end
  end

  // Hard error latches until reset; nothing short of reset recovers it
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_halted <= 1'b0;
    end else if (i_hard_err) begin
      o_halted <= 1'b1;
    end
  end

  // Red LED: retriggered soft-error pulse, ESR read clears, blink on halt
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      led_ms <= 8'h00;
      blink_ms <= 8'h00;
      o_err_led <= 1'b0;
    end else if (o_halted) begin
      if (ms_tick) begin
        blink_ms <= (blink_ms == 8'(gateway_pkg::BLINK_MS - 1)) ? 8'h00 : blink_ms + 8'h01;
        if (blink_ms == 8'(gateway_pkg::BLINK_MS - 1)) begin
          o_err_led <= !o_err_led;
        end
      end
    end else if (soft_err) begin
      led_ms <= 8'(gateway_pkg::LED_PULSE_MS);
      o_err_led <= 1'b1;
    end else if (rd_ok && i_addr == gateway_pkg::ESR_OFS) begin
      led_ms <= 8'h00;
      o_err_led <= 1'b0;
    end else if (ms_tick && led_ms != 8'h00) begin
      led_ms <= led_ms - 8'h01;
      o_err_led <= (led_ms != 8'h01);
    end
  end

  // Read data, registered; locked and unmapped addresses read zero
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 32'h00000000;
    end else if (rd_ok) begin
      case (i_addr)
        gateway_pkg::TIMEOUT_OFS: o_rdata <= 32'(timeout_ms);
        gateway_pkg::SLAVE_ADDR_OFS: o_rdata <= 32'(o_slave_addr);
        gateway_pkg::IDN_PTR_OFS: o_rdata <= 32'(idn_ptr);
        gateway_pkg::IDN_DATA_OFS: o_rdata <= 32'(idn[idn_ptr]);
        gateway_pkg::MB_ERR_OFS: o_rdata <= 32'(mb_err);
        gateway_pkg::ESR_OFS: o_rdata <= 32'({esr[7], mb_posted, esr[5:0]});
        gateway_pkg::ESE_OFS: o_rdata <= 32'(ese);
        gateway_pkg::SRE_OFS: o_rdata <= 32'(sre);
        gateway_pkg::QUES_EVENT_OFS: o_rdata <= 32'(ques_ev);
        gateway_pkg::QUES_ENABLE_OFS: o_rdata <= 32'(ques_en);
        gateway_pkg::QUES_PTR_OFS: o_rdata <= 32'(ques_ptr);
        gateway_pkg::STB_OFS: o_rdata <= 32'(stb);
        gateway_pkg::LOG_DATA_OFS: o_rdata <= (log_cnt != 5'h00) ?
                                             32'(log_mem[log_rp]) : 32'h00000000;
        gateway_pkg::LOG_COUNT_OFS: o_rdata <= 32'(log_cnt);
        gateway_pkg::STATUS_OFS: o_rdata <= 32'({o_halted, to_state, o_lock});
        gateway_pkg::IO_OFS: o_rdata <= 32'(o_io);
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule // gateway_supervisor

// ---- common/gateway_pkg.sv ----
/*
  Shared constants and carriers for the gateway supervision block.
  Assumes a 125 MHz single clock and a byte-addressed register port.
*/
package gateway_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] TIMEOUT_OFS = 8'h04;
  localparam logic [7:0] SLAVE_ADDR_OFS = 8'h08;
  localparam logic [7:0] IDN_PTR_OFS = 8'h0C;
  localparam logic [7:0] IDN_DATA_OFS = 8'h10;
  localparam logic [7:0] MB_ERR_OFS = 8'h14;
  localparam logic [7:0] ESR_OFS = 8'h18;
  localparam logic [7:0] ESE_OFS = 8'h1C;
  localparam logic [7:0] SRE_OFS = 8'h20;
  localparam logic [7:0] QUES_EVENT_OFS = 8'h24;
  localparam logic [7:0] QUES_ENABLE_OFS = 8'h28;
  localparam logic [7:0] QUES_PTR_OFS = 8'h2C;
  localparam logic [7:0] STB_OFS = 8'h30;
  localparam logic [7:0] LOG_DATA_OFS = 8'h34;
  localparam logic [7:0] LOG_COUNT_OFS = 8'h38;
  localparam logic [7:0] STATUS_OFS = 8'h3C;
  localparam logic [7:0] IO_OFS = 8'h40;
  // Command word fields: opcode [7:0], parameter [15:8]
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PARAM_LSB = 8;
  // Status bit positions
  localparam int ESR_QUERY_ERR_BIT = 2;
  localparam int ESR_CMD_ERR_BIT = 5;
  localparam int ESR_MB_ERR_BIT = 6;
  localparam int QUES_TIMEOUT_BIT = 12;
  localparam int QUES_CRC_BIT = 13;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_ESR_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  // Reset values
  localparam logic [15:0] TIMEOUT_RESET_MS = 16'h012C;
  localparam logic [7:0] SLAVE_ADDR_RESET = 8'h01;
  localparam logic [15:0] QUES_PTR_RESET = 16'h3000;
  // Error codes
  localparam logic [15:0] ERR_MB_TIMEOUT = 16'h0065;
  localparam logic [15:0] ERR_MB_CRC = 16'h0066;
  localparam logic [15:0] ERR_LOCKED_ACCESS = 16'h0067;
  // Sizes
  localparam int IDN_LEN = 72;
  localparam int LOG_DEPTH = 16;
  // Timing
  localparam int CLK_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int LED_PULSE_MS = 100;
  localparam int BLINK_MS = 250;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  typedef enum logic [7:0] {
    OP_NONE = 8'h00,
    OP_LOCK_ON = 8'h01,
    OP_LOCK_OFF = 8'h02,
    OP_SAVE = 8'h03,
    OP_RECALL = 8'h04,
    OP_DEV_CLEAR = 8'h05,
    OP_DEV_TRIGGER = 8'h06,
    OP_LOG_OPEN = 8'h07
  } cmd_op_e;

  // Configuration image held in nonvolatile memory
  typedef struct packed {
    logic lock;
    logic [15:0] timeout_ms;
    logic [7:0] slave_addr;
    logic [15:0] io;
  } nv_cfg_s;

  // Events from the Modbus serial engine
  typedef struct packed {
    logic req_sent;
    logic reply_seen;
    logic crc_err;
    logic err_valid;
    logic [15:0] err_code;
  } mb_evt_s;
endpackage

// ---- sim/gateway_supervisor_asserts.sv ----
/* Port checker for the gateway supervisor.
   Assumes one clock domain and a bind onto the design module. */
`timescale 1ns/100ps
module gateway_supervisor_asserts #(
  parameter int MS_CYCLES_P = 4
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic [7:0] i_addr, // Address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write
  input wire logic i_rd, // Read
  input wire logic i_hard_err, // Hard fault
  input wire logic [31:0] o_rdata, // Read data
  input wire gateway_pkg::nv_cfg_s o_nv, // Image
  input wire logic o_nv_save, // Store
  input wire logic o_ser_flush, // Flush
  input wire logic o_err_led, // LED
  input wire logic o_timeout, // Timeout
  input wire logic o_halted, // Halt
  input wire logic o_lock, // Lock
  input wire logic [7:0] o_slave_addr, // Slave address
  input wire logic [15:0] o_io // I/O
);
  // Accepted command and locked access; a halted block takes neither
  logic cmd;
  logic lk;
  assign cmd = i_wr && i_addr == gateway_pkg::CMD_OFS && !o_halted;
  assign lk = o_lock && !o_halted && (i_addr == gateway_pkg::SLAVE_ADDR_OFS
    || i_addr == gateway_pkg::IDN_PTR_OFS || i_addr == gateway_pkg::IDN_DATA_OFS);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_save; cmd && i_wdata[15:0] == {8'h00, gateway_pkg::OP_SAVE} |=> o_nv_save; endproperty
  a_save: assert property (p_save) else $error("store pulse missing");
  property p_image; o_nv_save |-> o_nv.lock == o_lock && o_nv.io == o_io; endproperty
  a_image: assert property (p_image) else $error("stored image differs");
  property p_flush; cmd && i_wdata[7:0] == gateway_pkg::OP_DEV_CLEAR |=> o_ser_flush; endproperty
  a_flush: assert property (p_flush) else $error("flush pulse missing");
  property p_lock_on; cmd && i_wdata[7:0] == gateway_pkg::OP_LOCK_ON |=> o_lock; endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock flag not set");
  property p_lk_rd; lk && i_rd |=> o_rdata == 32'h0 && o_err_led; endproperty
  a_lk_rd: assert property (p_lk_rd) else $error("locked read answered");
  property p_lk_wr; lk && i_wr |=> o_err_led && $stable(o_slave_addr); endproperty
  a_lk_wr: assert property (p_lk_wr) else $error("locked write took effect");
  property p_slave_wr;
    i_wr && i_addr == gateway_pkg::SLAVE_ADDR_OFS && !o_lock && !o_halted
      |=> o_slave_addr == $past(i_wdata[7:0]);
  endproperty
  a_slave_wr: assert property (p_slave_wr) else $error("address write lost");
  property p_to_led; o_timeout |-> ##[0:1] o_err_led; endproperty
  a_to_led: assert property (p_to_led) else $error("timeout left LED dark");
  property p_halt; i_hard_err |-> ##[1:2] o_halted; endproperty
  a_halt: assert property (p_halt) else $error("hard fault did not halt");
  c_timeout: cover property (o_timeout);
  c_save: cover property (o_nv_save);
  c_locked: cover property (lk && i_wr);
endmodule // gateway_supervisor_asserts
bind gateway_supervisor gateway_supervisor_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .i_hard_err(i_hard_err), .o_rdata(o_rdata), .o_nv(o_nv), .o_nv_save(o_nv_save),
  .o_ser_flush(o_ser_flush), .o_err_led(o_err_led), .o_timeout(o_timeout),
  .o_halted(o_halted), .o_lock(o_lock), .o_slave_addr(o_slave_addr), .o_io(o_io));

// ---- sim/modbus_slave_model.sv ----
/* Modbus slave seen from the gateway: request and reply events.
   Assumes the bench starts each query with a one-cycle go pulse. */
`timescale 1ns/100ps
module modbus_slave_model (
  input wire logic i_ref_clk, // Clock
  input wire logic i_go, // Start one query
  input wire logic [7:0] i_dly, // Reply delay, 0 = silent
  input wire logic i_crc, // Reply with bad check
  input wire logic [15:0] i_code, // Exception code, 0 = none
  output gateway_pkg::mb_evt_s o_mb = '0 // Events to the block
);
  int cnt = 0;
  // A silent slave never answers, so the gateway window must expire
  always @(posedge i_ref_clk) begin
    o_mb <= '0;
    if (i_go) begin
      o_mb.req_sent <= 1'b1;
      cnt <= i_dly;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_mb.reply_seen <= 1'b1;
      o_mb.crc_err <= i_crc;
      o_mb.err_valid <= i_code != 16'h0000;
      o_mb.err_code <= i_code;
    end
  end
endmodule // modbus_slave_model

// ---- sim/modbus_gateway_status_lock_tb_top.sv ----
/* Self-checking bench for the gateway supervisor with a slave model.
   Assumes a shortened millisecond tick of four clocks. */
`timescale 1ns/100ps
module modbus_gateway_status_lock_tb_top;
  localparam int MSC = 4;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_hard_err = 1'b0;
  logic go = 1'b0;
  logic crc = 1'b0;
  logic [7:0] dly = 8'h00;
  logic [15:0] code = 16'h0000;
  gateway_pkg::nv_cfg_s i_nv = '0;
  gateway_pkg::mb_evt_s mb;
  gateway_pkg::nv_cfg_s o_nv;
  logic [31:0] o_rdata, rnd, m;
  logic o_nv_save, o_ser_flush, o_err_led, o_srq, o_timeout, o_halted, o_lock, rd_pend = 1'b0;
  logic [7:0] o_slave_addr;
  logic [15:0] o_io;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int n_fail = 0;
  int checked = 0;
  int k;
  always #4 i_ref_clk = ~i_ref_clk;
  gateway_supervisor #(.MS_CYCLES_P(MSC)) i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_mb(mb), .i_nv(i_nv),
    .i_hard_err(i_hard_err), .o_rdata(o_rdata), .o_nv(o_nv), .o_nv_save(o_nv_save),
    .o_ser_flush(o_ser_flush), .o_err_led(o_err_led), .o_srq(o_srq), .o_timeout(o_timeout),
    .o_halted(o_halted), .o_lock(o_lock), .o_slave_addr(o_slave_addr), .o_io(o_io));
  modbus_slave_model i_slave (.i_ref_clk(i_ref_clk), .i_go(go), .i_dly(dly), .i_crc(crc),
    .i_code(code), .o_mb(mb));
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk = '1);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(x);
    msk_q.push_back(mk);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask
  // Slave query; one-cycle go pulse carrying reply delay, bad-check flag and code
  task automatic query(input logic [7:0] d, input logic c, input logic [15:0] cd);
    @(posedge i_ref_clk);
    go <= 1'b1;
    dly <= d;
    crc <= c;
    code <= cd;
    @(posedge i_ref_clk);
    go <= 1'b0;
  endtask
  task automatic await(input bit led);
    for (k = 0; k < 60; k++) begin
      @(posedge i_ref_clk);
      if ((led ? o_err_led : o_timeout) === 1'b1) break;
    end
    if (k == 60) begin
      n_fail++;
      test_done();
    end
  endtask
  // Read data is due in the cycle after the read edge only
  always @(posedge i_ref_clk) begin
    if (rd_pend) begin
      m = msk_q.pop_front();
      chk("rdata", exp_q.pop_front() & m, o_rdata & m);
    end
    rd_pend <= i_rd;
  end
  initial begin
    rnd = $urandom(32'hF400);
    rnd = $urandom;
    i_nv.io = rnd[15:0];
    i_nv.slave_addr = rnd[23:16];
    i_nv.lock = rnd[24];
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk("boot", {i_nv.lock, i_nv.slave_addr, i_nv.io}, {o_lock, o_slave_addr, o_io});
    wr(gateway_pkg::CMD_OFS, 32'h2);
    rd(gateway_pkg::QUES_PTR_OFS, 32'h3000);
    wr(gateway_pkg::TIMEOUT_OFS, 32'h2);
    rd(gateway_pkg::TIMEOUT_OFS, 32'h2);
    wr(gateway_pkg::QUES_ENABLE_OFS, 32'h3000);
    wr(gateway_pkg::ESE_OFS, 32'h60);
    wr(gateway_pkg::SRE_OFS, 32'h28);
    wr(gateway_pkg::CMD_OFS, 32'h7);
    rd(gateway_pkg::LOG_COUNT_OFS, 32'h0);
    query(8'd0, 1'b0, 16'h0);
    await(1'b0);
    chk("window", 32'h1, 32'(k >= 4 && k <= 20));
    #1 chk("srq", 32'h1, 32'(o_srq));
    rd(gateway_pkg::STB_OFS, 32'h28, 32'h28);
    rd(gateway_pkg::MB_ERR_OFS, 32'h65, 32'hFFFF);
    rd(gateway_pkg::QUES_EVENT_OFS, 32'h1000, 32'h3000);
    rd(gateway_pkg::QUES_EVENT_OFS, 32'h0, 32'h3000);
    rd(gateway_pkg::ESR_OFS, 32'h0, 32'h40);
    repeat (2) @(posedge i_ref_clk);
    #1 chk("srq_led", 32'h0, {o_srq, o_err_led});
    query(8'd3, 1'b0, 16'h0);
    repeat (40) @(posedge i_ref_clk);
    #1 chk("reply_led", 32'h0, 32'(o_err_led));
    query(8'd2, 1'b1, 16'h0);
    await(1'b1);
    repeat (360) @(posedge i_ref_clk);
    #1 chk("led_on", 32'h1, 32'(o_err_led));
    repeat (80) @(posedge i_ref_clk);
    #1 chk("led_off", 32'h0, 32'(o_err_led));
    rd(gateway_pkg::MB_ERR_OFS, 32'h66, 32'hFFFF);
    rd(gateway_pkg::LOG_COUNT_OFS, 32'h2, 32'hFF);
    rd(gateway_pkg::LOG_DATA_OFS, 32'h65, 32'hFFFF);
    query(8'd2, 1'b0, rnd[31:16] | 16'h1);
    repeat (8) @(posedge i_ref_clk);
    rd(gateway_pkg::MB_ERR_OFS, {16'h0, rnd[31:16] | 16'h1}, 32'hFFFF);
    wr(gateway_pkg::IDN_DATA_OFS, 32'h41);
    wr(gateway_pkg::CMD_OFS, 32'h1);
    rd(gateway_pkg::SLAVE_ADDR_OFS, 32'h0);
    rd(gateway_pkg::IDN_DATA_OFS, 32'h0);
    wr(gateway_pkg::SLAVE_ADDR_OFS, {24'h0, ~i_nv.slave_addr});
    rd(gateway_pkg::ESR_OFS, 32'h20, 32'h20);
    wr(gateway_pkg::IO_OFS, rnd);
    wr(gateway_pkg::CMD_OFS, 32'h3);
    #1 chk("save", {2'b11, rnd[15:0]}, {o_nv_save, o_nv.lock, o_nv.io});
    wr(gateway_pkg::CMD_OFS, 32'h103);
    #1 chk("save_p1", 32'h0, 32'(o_nv_save));
    wr(gateway_pkg::CMD_OFS, 32'h4);
    repeat (2) @(posedge i_ref_clk);
    #1 chk("recall", {i_nv.lock, i_nv.io}, {o_lock, o_io});
    wr(gateway_pkg::CMD_OFS, 32'h5);
    #1 chk("flush", 32'h1, 32'(o_ser_flush));
    wr(gateway_pkg::CMD_OFS, 32'h6);
    #1 chk("trigger", 32'h0, {o_ser_flush, o_nv_save});
    @(posedge i_ref_clk) i_hard_err <= 1'b1;
    wr(gateway_pkg::IO_OFS, ~rnd);
    rd(gateway_pkg::IO_OFS, 32'h0);
    #1 chk("halt", {1'b1, i_nv.io}, {o_halted, o_io});
    repeat (3) @(posedge i_ref_clk);
    test_done();
  end
endmodule // modbus_gateway_status_lock_tb_top
